// ==== spp_stack.sv ====
`timescale 1ns/1ps
// stack selector, stack pointer and push/pop sequencer
// Notes on behaviour
// - push: lower the pointer first, then write at the new top.
// - pop: read the current top first, then raise the pointer.
// - every stack access uses the stack selector and its segment.
// - one stack is active: the one the held selector names.
// - call, return, push, pop, enter, leave all use the current stack.
// - pointer and offsets cover the full 4 GB segment range.
// - combined far-pointer load writes selector and pointer together.
// - step is 2 bytes for a 16-bit stack, 4 for a 32-bit one.
module spp_stack
    import spp_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire spp_req_t req,
    input wire spp_load_t load,
    input wire logic load_stack_far_pointer,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic busy,
    output logic done,
    output logic [31:0] pop_data,
    output spp_mem_t mem,
    output logic [15:0] stack_sel,
    output logic [31:0] stack_pointer_reg,
    output logic stack_wide
);
    typedef enum logic [1:0] {
        SPP_IDLE = 2'b00,
        SPP_WR = 2'b01,
        SPP_RD = 2'b10
    } spp_state_t;

    spp_state_t state, next_state;
    logic [31:0] base, next_base;
    logic [15:0] next_sel;
    logic [31:0] next_sp, next_pop_data;
    logic next_wide, next_busy, next_done;
    spp_mem_t next_mem;
    logic [31:0] sp_dec, sp_inc;
    logic idle, take_push, take_pop, take_any;
    logic wr_end, rd_end;
    logic sel_load, sp_load;

    spp_step u_step (
        .wide(stack_wide),
        .sp(stack_pointer_reg),
        .sp_dec(sp_dec),
        .sp_inc(sp_inc)
    );

    // push-like ops write, pop-like ops read; none and spare codes idle
    function automatic logic is_push(input spp_op_t op);
        case (op)
            SPP_OP_PUSH, SPP_OP_CALL, SPP_OP_ENTER: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic is_pop(input spp_op_t op);
        case (op)
            SPP_OP_POP, SPP_OP_RET, SPP_OP_LEAVE: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // segment base plus offset; the sum wraps at 4 GB like the pointer
    function automatic logic [31:0] seg_addr(
        input logic [31:0] seg_base,
        input logic [31:0] offset
    );
        return seg_base + offset;
    endfunction

    // request and completion decode shared by the groups below
    always_comb begin
        idle = state == SPP_IDLE;
        // requests are only taken while no access is in flight
        take_push = idle && req.valid && is_push(req.op);
        take_pop = idle && req.valid && is_pop(req.op);
        take_any = take_push || take_pop;
        wr_end = state == SPP_WR && mem_ack;
        rd_end = state == SPP_RD && mem_ack;
        // a taken access owns the cycle, so a load in it is dropped
        sel_load = load_stack_far_pointer || load.sel_we;
        sel_load = sel_load && idle && !take_any;
        sp_load = load_stack_far_pointer || load.sp_we;
        sp_load = sp_load && idle && !take_any;
    end

    // selector group: names the one active stack
    always_comb begin
        next_sel = stack_sel;
        next_base = base;
        next_wide = stack_wide;
        if (sel_load) begin
            next_sel = load.sel;
            next_base = load.base;
            next_wide = load.wide;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stack_sel <= SPP_SEL_RST;
            base <= SPP_BASE_RST;
            stack_wide <= SPP_WIDE_RST;
        end else begin
            stack_sel <= next_sel;
            base <= next_base;
            stack_wide <= next_wide;
        end
    end

    // pointer group: loads, push decrement, pop increment
    always_comb begin
        next_sp = stack_pointer_reg;
        if (sp_load) begin
            next_sp = load.sp;
        end
        if (take_push) begin
            next_sp = sp_dec;
        end
        if (rd_end) begin
            next_sp = sp_inc;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stack_pointer_reg <= SPP_SP_RST;
        end else begin
            stack_pointer_reg <= next_sp;
        end
    end

    // sequencer: one access in flight, request held until ack
    always_comb begin
        next_state = state;
        next_mem = mem;
        unique case (state)
            SPP_IDLE: begin
                if (take_push) begin
                    next_mem.addr = seg_addr(base, sp_dec);
                    next_mem.sel = stack_sel;
                    next_mem.we = 1'b1;
                    next_mem.req = 1'b1;
                    next_mem.wdata = req.data;
                    next_state = SPP_WR;
                end else if (take_pop) begin
                    next_mem.addr = seg_addr(base, stack_pointer_reg);
                    next_mem.sel = stack_sel;
                    next_mem.we = 1'b0;
                    next_mem.req = 1'b1;
                    next_state = SPP_RD;
                end
            end
            SPP_WR: begin
                // write data stays on the bus until the ack edge
                if (wr_end) begin
                    next_mem.req = 1'b0;
                    next_mem.we = 1'b0;
                    next_state = SPP_IDLE;
                end
            end
            SPP_RD: begin
                // the pointer moves in its own group
                if (rd_end) begin
                    next_mem.req = 1'b0;
                    next_state = SPP_IDLE;
                end
            end
            default: next_state = SPP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= SPP_IDLE;
            mem <= '0;
        end else begin
            state <= next_state;
            mem <= next_mem;
        end
    end

    // results: done pulse, busy level, last popped word
    always_comb begin
        next_done = wr_end || rd_end;
        // busy follows the next state so it stays flop-driven
        next_busy = next_state != SPP_IDLE;
        next_pop_data = pop_data;
        // the word is only valid in the ack cycle, so take it there
        if (rd_end) begin
            next_pop_data = mem_rdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            done <= 1'b0;
            busy <= 1'b0;
            pop_data <= SPP_DATA_RST;
        end else begin
            done <= next_done;
            busy <= next_busy;
            pop_data <= next_pop_data;
        end
    end
endmodule

// ==== spp_pkg.sv ====
// shared types and constants for the stack push/pop block
package spp_pkg;
    localparam int SPP_AW = 32;
    localparam int SPP_SELW = 16;
    localparam logic [31:0] SPP_STEP16 = 32'h0000_0002;
    localparam logic [31:0] SPP_STEP32 = 32'h0000_0004;
    localparam logic [31:0] SPP_SP_RST = 32'h0000_0000;
    localparam logic [15:0] SPP_SEL_RST = 16'h0000;
    localparam logic [31:0] SPP_BASE_RST = 32'h0000_0000;
    localparam logic SPP_WIDE_RST = 1'b1;
    localparam logic [31:0] SPP_DATA_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        SPP_OP_NONE = 3'b000,
        SPP_OP_PUSH = 3'b001,
        SPP_OP_POP = 3'b010,
        SPP_OP_CALL = 3'b011,
        SPP_OP_RET = 3'b100,
        SPP_OP_ENTER = 3'b101,
        SPP_OP_LEAVE = 3'b110
    } spp_op_t;

    typedef struct packed {
        logic valid;
        spp_op_t op;
        logic [31:0] data;
    } spp_req_t;

    typedef struct packed {
        logic sel_we;
        logic [15:0] sel;
        logic [31:0] base;
        logic wide;
        logic sp_we;
        logic [31:0] sp;
    } spp_load_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] sel;
        logic [31:0] addr;
        logic [31:0] wdata;
    } spp_mem_t;
endpackage

// ==== spp_step.sv ====
`timescale 1ns/1ps
// step size and pointer arithmetic for one stack access
module spp_step
    import spp_pkg::*;
(
    input wire logic wide,
    input wire logic [31:0] sp,
    output logic [31:0] sp_dec,
    output logic [31:0] sp_inc
);
    logic [31:0] step;
    always_comb begin
        step = wide ? SPP_STEP32 : SPP_STEP16;
        // full 32-bit offset, wraps modulo 4 GB
        sp_dec = sp - step;
        sp_inc = sp + step;
    end
endmodule

// ==== spp_checker.sv ====
// assertions for the stack push/pop block
`timescale 1ns/1ps
module spp_checker
    import spp_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire spp_req_t req,
    input wire spp_load_t load,
    input wire logic load_stack_far_pointer,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic busy,
    input wire logic done,
    input wire logic [31:0] pop_data,
    input wire spp_mem_t mem,
    input wire logic [15:0] stack_sel,
    input wire logic [31:0] stack_pointer_reg,
    input wire logic stack_wide
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic [31:0] stp;
    logic tk, psh, pp, ld_ok;
    assign stp = stack_wide ? SPP_STEP32 : SPP_STEP16;
    assign tk = !busy && req.valid;
    assign psh = tk && req.op inside {SPP_OP_PUSH, SPP_OP_CALL, SPP_OP_ENTER};
    assign pp = tk && req.op inside {SPP_OP_POP, SPP_OP_RET, SPP_OP_LEAVE};
    // a request of any op skips the load checks; the design drops loads only on push or pop
    assign ld_ok = !busy && !tk;
    a_push_dec: assert property (psh |=> mem.req && mem.we &&
        stack_pointer_reg == $past(stack_pointer_reg) - $past(stp))
        else $error("push step");
    a_pop_read: assert property (pp |=> mem.req && !mem.we &&
        $stable(stack_pointer_reg)) else $error("pop read");
    a_pop_inc: assert property (mem.req && !mem.we && mem_ack |=>
        done && pop_data == $past(mem_rdata) &&
        stack_pointer_reg == $past(stack_pointer_reg) + $past(stp))
        else $error("pop step");
    a_seg_sel: assert property (mem.req |-> mem.sel == stack_sel)
        else $error("selector");
    a_req_hold: assert property (mem.req && !mem_ack |=> $stable(mem))
        else $error("request hold");
    a_end_done: assert property (mem.req && mem_ack |=>
        done && !busy && !mem.req) else $error("done");
    a_none_idle: assert property (tk && req.op == SPP_OP_NONE |=>
        !busy && !mem.req) else $error("no-op started an access");
    a_far_load: assert property (ld_ok && load_stack_far_pointer |=>
        stack_sel == $past(load.sel) && stack_pointer_reg == $past(load.sp))
        else $error("far load");
    a_sp_load: assert property (ld_ok && load.sp_we &&
        !load_stack_far_pointer |=> stack_pointer_reg == $past(load.sp))
        else $error("pointer load");
    a_sel_load: assert property (ld_ok && load.sel_we &&
        !load_stack_far_pointer |=> stack_sel == $past(load.sel) &&
        stack_wide == $past(load.wide)) else $error("selector load");
    c_push: cover property (psh);
    c_pop: cover property (pp);
    c_far: cover property (ld_ok && load_stack_far_pointer);
endmodule

bind spp_stack spp_checker u_chk (.*);

// ==== spp_mem_model.sv ====
// stack memory partner with adjustable answer delay
`timescale 1ns/1ps
module spp_mem_model
    import spp_pkg::*;
(
    input wire logic core_clk,
    input wire spp_mem_t mem,
    input wire logic [1:0] lat,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] store [logic [47:0]];
    logic [1:0] cnt = 2'h0;
    initial mem_ack = 1'b0;
    initial mem_rdata = 32'h0;
    always @(posedge core_clk) begin
        if (mem.req && !mem_ack && cnt == lat) begin
            mem_ack <= 1'b1;
            cnt <= 2'h0;
            if (mem.we)
                store[{mem.sel, mem.addr}] = mem.wdata;
            mem_rdata <= store[{mem.sel, mem.addr}];
        end else begin
            mem_ack <= 1'b0;
            // data is stale outside an answer
            mem_rdata <= ~mem_rdata;
            if (mem.req && !mem_ack)
                cnt <= cnt + 2'h1;
        end
    end
endmodule

// ==== tb.sv ====
// self-checking bench for the stack push/pop block
`timescale 1ns/1ps
module tb import spp_pkg::*; ();
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic load_stack_far_pointer = 1'b0;
    spp_req_t req = '0;
    spp_load_t load = '0;
    logic mem_ack, busy, done, stack_wide, xw;
    logic [31:0] mem_rdata, pop_data, stack_pointer_reg, xsp, xb, d, sv;
    logic [15:0] stack_sel, xsel;
    spp_mem_t mem;
    logic [1:0] lat = 2'h0;
    logic [31:0] rm [logic [47:0]];
    int err_count = 0;
    int comparisons = 0;
    int seed = 46;
    always #10 core_clk = ~core_clk;
    spp_stack uut (.*);
    spp_mem_model mdl (.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic ld(input spp_load_t l, input logic f);
        @(posedge core_clk);
        load <= l;
        load_stack_far_pointer <= f;
        @(posedge core_clk);
        load <= '0;
        load_stack_far_pointer <= 1'b0;
        if (f || l.sel_we) {xsel, xb, xw} = {l.sel, l.base, l.wide};
        if (f || l.sp_we) xsp = l.sp;
    endtask
    task automatic op(input spp_op_t o);
        int n;
        logic pu;
        pu = o inside {SPP_OP_PUSH, SPP_OP_CALL, SPP_OP_ENTER};
        d = $random(seed);
        @(posedge core_clk);
        req <= '{1'b1, o, d};
        lat <= d[1:0];
        @(posedge core_clk);
        req.valid <= 1'b0;
        if (pu) xsp = xsp - (xw ? SPP_STEP32 : SPP_STEP16);
        #1;
        chk(mem.addr, xb + xsp);
        chk({15'h0, mem.we}, {15'h0, pu});
        chk({16'h0, mem.sel}, {16'h0, xsel});
        chk({31'h0, busy}, 32'h1);
        if (pu) chk(mem.wdata, d);
        if (pu) rm[{xsel, xb + xsp}] = d;
        for (n = 0; n < 20 && done !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (n == 20) begin
            err_count++;
            stop_test;
        end
        if (!pu) chk(pop_data, rm[{xsel, xb + xsp}]);
        if (!pu) xsp = xsp + (xw ? SPP_STEP32 : SPP_STEP16);
        chk(stack_pointer_reg, xsp);
    endtask
    initial begin
        {xsp, xb, xsel, xw} = {32'h0, 32'h0, 16'h0, 1'b1};
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk({16'h0, stack_sel}, {16'h0, SPP_SEL_RST});
        chk({31'h0, stack_wide}, {31'h0, SPP_WIDE_RST});
        chk(stack_pointer_reg, SPP_SP_RST);
        chk({29'h0, busy, done, mem.req}, 32'h0);
        ld('{1'b1, 16'h0010, 32'h1000, 1'b1, 1'b0, 32'h0}, 1'b0);
        ld('{1'b0, 16'h0, 32'h0, 1'b0, 1'b1, 32'h0100}, 1'b0);
        op(SPP_OP_PUSH);
        op(SPP_OP_CALL);
        op(SPP_OP_ENTER);
        op(SPP_OP_LEAVE);
        op(SPP_OP_RET);
        sv = xsp;
        // 16-bit stack at 2 wraps below zero
        ld('{1'b0, 16'h0020, 32'h8000, 1'b0, 1'b0, 32'h2}, 1'b1);
        op(SPP_OP_PUSH);
        op(SPP_OP_PUSH);
        op(SPP_OP_POP);
        op(SPP_OP_POP);
        // a request with no operation leaves the stack alone
        @(posedge core_clk);
        req <= '{1'b1, SPP_OP_NONE, 32'h0};
        @(posedge core_clk);
        req.valid <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(stack_pointer_reg, xsp);
        chk({30'h0, busy, mem.req}, 32'h0);
        ld('{1'b0, 16'h0010, 32'h1000, 1'b1, 1'b0, sv}, 1'b1);
        op(SPP_OP_POP);
        stop_test;
    end
endmodule
